// [design/smpc_pkg.sv]
// Constants and types shared by the sensor power-mode control block
package smpc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_INACT_THRESH = 8'h25;
    localparam logic [7:0] ADDR_INACT_TIME = 8'h26;
    localparam logic [7:0] ADDR_RATE = 8'h2C;
    localparam logic [7:0] ADDR_POWER = 8'h2D;
    localparam logic [7:0] ADDR_MODE_STATUS = 8'h3F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PWR_MEASURE_BIT = 3;
    localparam int PWR_AUTOSLEEP_BIT = 4;
    localparam int PWR_LINK_BIT = 5;
    localparam int RATE_LOWPWR_BIT = 4;
    localparam int RATE_CODE_LSB = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_INACT_THRESH = 8'h00;
    localparam logic [7:0] RST_INACT_TIME = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h0A;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Rate codes
    // ------------------------------------------------------------------
    localparam logic [3:0] RATE_CODE_MAX = 4'hF;
    localparam logic [3:0] RATE_CODE_MIN = 4'h6;
    localparam logic [3:0] LP_CODE_LO = 4'h7;
    localparam logic [3:0] LP_CODE_HI = 4'hC;
    localparam logic [3:0] SLEEP_RATE_CODE = 4'h6;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int ODR_MAX_HZ = 3200;
    localparam int TICK_MAX_CYCLES = CLK_HZ / ODR_MAX_HZ;
    localparam int INACT_UNIT_S = 1;
    localparam int SECOND_CYCLES = CLK_HZ * INACT_UNIT_S;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_MEASURE = 2'b01,
        MODE_SLEEP = 2'b10
    } smpc_mode_e;

endpackage

// [design/smpc_rate_if.sv]
// Carrier between the mode controller and the sample rate generator
interface smpc_rate_if;
    logic run;
    logic [3:0] rate_code;
    logic lp_sel;
    logic out_tick;
    logic conv_tick;

    modport gen (
        input run,
        input rate_code,
        input lp_sel,
        output out_tick,
        output conv_tick
    );

    modport ctl (
        output run,
        output rate_code,
        output lp_sel,
        input out_tick,
        input conv_tick
    );
endinterface

// [design/smpc_rate_gen.sv]
// Output data rate and internal conversion tick generator
module smpc_rate_gen
    import smpc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_MAX_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    smpc_rate_if.gen rif
);

    localparam logic [23:0] BASE_PERIOD = 24'(TICK_CYCLES);

    logic [23:0] cnt_r;
    logic tick_r;
    logic conv_r;
    logic phase_r;

    // ------------------------------------------------------------------
    // Period decode
    // ------------------------------------------------------------------
    // Codes below the slowest rate clamp to it
    wire logic [3:0] eff_code_w = (rif.rate_code < RATE_CODE_MIN) ?
        RATE_CODE_MIN : rif.rate_code;
    // Each code step below the top halves the rate
    wire logic [3:0] shift_w = RATE_CODE_MAX - eff_code_w;
    wire logic [23:0] period_w = BASE_PERIOD << shift_w;
    wire logic wrap_w = (cnt_r >= (period_w - 24'h000001));
    // Reduced sampling only pays off in the mid rate band
    wire logic lp_range_w = rif.lp_sel && (eff_code_w >= LP_CODE_LO) &&
        (eff_code_w <= LP_CODE_HI);

    // ------------------------------------------------------------------
    // Counter and ticks
    // ------------------------------------------------------------------
    // Halted counter produces no ticks at all
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 24'h000000;
            tick_r <= 1'b0;
            conv_r <= 1'b0;
            phase_r <= 1'b0;
        end else if (ce) begin
            if (!rif.run) begin
                cnt_r <= 24'h000000;
                tick_r <= 1'b0;
                conv_r <= 1'b0;
                phase_r <= 1'b0;
            end else begin
                cnt_r <= wrap_w ? 24'h000000 : cnt_r + 24'h000001;
                tick_r <= wrap_w;
                conv_r <= wrap_w && (!lp_range_w || phase_r);
                phase_r <= wrap_w ? ~phase_r : phase_r;
            end
        end
    end

    assign rif.out_tick = tick_r;
    assign rif.conv_tick = conv_r;

endmodule // smpc_rate_gen

// [design/smpc_power_ctrl.sv]
// Power-mode controller: registers, mode machine, autosleep timer
module smpc_power_ctrl
    import smpc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_MAX_CYCLES,
    parameter int SEC_CYCLES = SECOND_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic main_supply_ok,
    input wire logic interface_supply_ok,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic sample_valid,
    input wire logic [7:0] sample_level,
    output logic [7:0] reg_rdata,
    output logic [1:0] mode,
    output logic sample_tick,
    output logic conv_tick,
    output logic low_power_active
);

    localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);

    smpc_mode_e state_r;
    smpc_mode_e state_nxt;
    logic [1:0] main_sync_r;
    logic [1:0] iface_sync_r;
    logic [7:0] inactivity_threshold_r;
    logic [7:0] inactivity_time_r;
    logic [7:0] rate_and_power_select_r;
    logic [7:0] power_control_r;
    logic [7:0] reg_rdata_r;
    logic [25:0] sub_cnt_r;
    logic [7:0] sec_cnt_r;
    logic sample_tick_r;
    logic conv_tick_r;
    logic low_power_active_r;

    smpc_rate_if rif ();

    // ------------------------------------------------------------------
    // Supply level synchronisers
    // ------------------------------------------------------------------
    // Supply flags arrive from outside the clock domain
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            main_sync_r <= 2'h0;
            iface_sync_r <= 2'h0;
        end else if (ce) begin
            main_sync_r <= {main_sync_r[0], main_supply_ok};
            iface_sync_r <= {iface_sync_r[0], interface_supply_ok};
        end
    end

    wire logic main_ok_w = main_sync_r[1];
    wire logic iface_ok_w = iface_sync_r[1];

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Port is live whenever the interface supply is up, in any mode
    wire logic wr_ok_w = reg_wr && iface_ok_w;
    wire logic wr_thresh_w = wr_ok_w && (reg_addr == ADDR_INACT_THRESH);
    wire logic wr_time_w = wr_ok_w && (reg_addr == ADDR_INACT_TIME);
    wire logic wr_rate_w = wr_ok_w && (reg_addr == ADDR_RATE);
    wire logic wr_power_w = wr_ok_w && (reg_addr == ADDR_POWER);
    wire logic [7:0] status_w = {6'h00, state_r};
    wire logic [7:0] rd_mux_w =
        (reg_addr == ADDR_INACT_THRESH) ? inactivity_threshold_r :
        (reg_addr == ADDR_INACT_TIME) ? inactivity_time_r :
        (reg_addr == ADDR_RATE) ? rate_and_power_select_r :
        (reg_addr == ADDR_POWER) ? power_control_r :
        (reg_addr == ADDR_MODE_STATUS) ? status_w : RD_UNMAPPED;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    wire logic measure_w = power_control_r[PWR_MEASURE_BIT];
    // Autosleep needs both the enable and the link bit
    wire logic auto_on_w = power_control_r[PWR_AUTOSLEEP_BIT] &&
        power_control_r[PWR_LINK_BIT];
    wire logic lp_bit_w = rate_and_power_select_r[RATE_LOWPWR_BIT];
    wire logic [3:0] code_w = rate_and_power_select_r[RATE_CODE_LSB +: 4];
    // Activity means a sample strictly above the threshold
    wire logic active_w = sample_valid &&
        (sample_level > inactivity_threshold_r);
    wire logic restart_w = !auto_on_w || (state_r != MODE_MEASURE) ||
        active_w;
    // A zero time never triggers sleep
    wire logic timeout_w = (inactivity_time_r != 8'h00) &&
        (sec_cnt_r >= inactivity_time_r);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Host writes, plus registered read data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            inactivity_threshold_r <= RST_INACT_THRESH;
            inactivity_time_r <= RST_INACT_TIME;
            rate_and_power_select_r <= RST_RATE;
            power_control_r <= RST_POWER;
            reg_rdata_r <= RD_UNMAPPED;
        end else if (ce) begin
            if (wr_thresh_w) inactivity_threshold_r <= reg_wdata;
            if (wr_time_w) inactivity_time_r <= reg_wdata;
            if (wr_rate_w) rate_and_power_select_r <= reg_wdata;
            if (wr_power_w) power_control_r <= reg_wdata;
            if (reg_rd) reg_rdata_r <= iface_ok_w ? rd_mux_w : RD_UNMAPPED;
        end
    end

    // ------------------------------------------------------------------
    // Mode machine
    // ------------------------------------------------------------------
    // Next mode from measure bit, supplies and inactivity
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            MODE_STANDBY: begin
                if (measure_w && main_ok_w && iface_ok_w) begin
                    state_nxt = MODE_MEASURE;
                end
            end
            MODE_MEASURE: begin
                if (!measure_w || !main_ok_w) begin
                    state_nxt = MODE_STANDBY;
                end else if (auto_on_w && timeout_w) begin
                    state_nxt = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (!measure_w || !main_ok_w) begin
                    state_nxt = MODE_STANDBY;
                end else if (!auto_on_w) begin
                    state_nxt = MODE_MEASURE;
                end
            end
            default: begin
                state_nxt = MODE_STANDBY;
            end
        endcase
    end

    // Reset leaves the part in standby
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= MODE_STANDBY;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Inactivity timer
    // ------------------------------------------------------------------
    // Whole seconds of inactivity, saturating
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sub_cnt_r <= 26'h0000000;
            sec_cnt_r <= 8'h00;
        end else if (ce) begin
            if (restart_w) begin
                sub_cnt_r <= 26'h0000000;
                sec_cnt_r <= 8'h00;
            end else if (sub_cnt_r == SEC_LAST) begin
                sub_cnt_r <= 26'h0000000;
                if (sec_cnt_r != 8'hFF) sec_cnt_r <= sec_cnt_r + 8'h01;
            end else begin
                sub_cnt_r <= sub_cnt_r + 26'h0000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sample rate generation
    // ------------------------------------------------------------------
    // Standby halts sampling; no buffer is cleared on the way
    assign rif.run = (state_r != MODE_STANDBY);
    // Sleep drops to the slowest rate
    assign rif.rate_code = (state_r == MODE_SLEEP) ? SLEEP_RATE_CODE :
        code_w;
    assign rif.lp_sel = lp_bit_w;

    smpc_rate_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_rate_gen (
        .clock(clock),
        .reset_n(reset_n),
        .ce(ce),
        .rif(rif.gen)
    );

    // Output stage, every output from a flop
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sample_tick_r <= 1'b0;
            conv_tick_r <= 1'b0;
            low_power_active_r <= 1'b0;
        end else if (ce) begin
            sample_tick_r <= rif.out_tick && rif.run;
            conv_tick_r <= rif.conv_tick && rif.run;
            low_power_active_r <= lp_bit_w;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign mode = state_r;
    assign sample_tick = sample_tick_r;
    assign conv_tick = conv_tick_r;
    assign low_power_active = low_power_active_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_supply_standby;
        @(posedge clock) disable iff (!reset_n)
        (ce && !main_ok_w) |=> (state_r == MODE_STANDBY);
    endproperty
    a_supply_standby: assert property (p_supply_standby)
        else $error("mode not standby without main supply");

    property p_enter_measure;
        @(posedge clock) disable iff (!reset_n)
        (ce && state_r == MODE_STANDBY && measure_w && main_ok_w &&
            iface_ok_w) |=> (state_r == MODE_MEASURE);
    endproperty
    a_enter_measure: assert property (p_enter_measure)
        else $error("measure bit did not start measurement");

    property p_leave_measure;
        @(posedge clock) disable iff (!reset_n)
        (ce && state_r == MODE_MEASURE && !measure_w) |=>
            (state_r == MODE_STANDBY);
    endproperty
    a_leave_measure: assert property (p_leave_measure)
        else $error("clearing measure did not reach standby");

    property p_write_any_mode;
        @(posedge clock) disable iff (!reset_n)
        (ce && wr_thresh_w) |=> (inactivity_threshold_r == $past(reg_wdata));
    endproperty
    a_write_any_mode: assert property (p_write_any_mode)
        else $error("threshold write lost");

    property p_standby_quiet;
        @(posedge clock) disable iff (!reset_n)
        (state_r == MODE_STANDBY) [*3] |-> (!sample_tick_r && !conv_tick_r);
    endproperty
    a_standby_quiet: assert property (p_standby_quiet)
        else $error("sample tick while in standby");

    property p_lp_flag;
        @(posedge clock) disable iff (!reset_n)
        ce ##1 ce |-> (low_power_active_r == $past(lp_bit_w));
    endproperty
    a_lp_flag: assert property (p_lp_flag)
        else $error("low power flag does not follow select bit");

    property p_sleep_cause;
        @(posedge clock) disable iff (!reset_n)
        $rose(state_r == MODE_SLEEP) |->
            ($past(timeout_w) && $past(auto_on_w));
    endproperty
    a_sleep_cause: assert property (p_sleep_cause)
        else $error("sleep entered before inactivity time");

    property p_sleep_entry;
        @(posedge clock) disable iff (!reset_n)
        (ce && state_r == MODE_MEASURE && measure_w && main_ok_w &&
            auto_on_w && timeout_w) |=> (state_r == MODE_SLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("inactivity timeout did not enter sleep");

    property p_timer_restart;
        @(posedge clock) disable iff (!reset_n)
        (ce && (active_w || !auto_on_w)) |=>
            (sec_cnt_r == 8'h00 && sub_cnt_r == 26'h0000000);
    endproperty
    a_timer_restart: assert property (p_timer_restart)
        else $error("inactivity timer not restarted");

    property p_sleep_to_standby;
        @(posedge clock) disable iff (!reset_n)
        (ce && state_r == MODE_SLEEP && !measure_w) |=>
            (state_r == MODE_STANDBY && sec_cnt_r == 8'h00);
    endproperty
    a_sleep_to_standby: assert property (p_sleep_to_standby)
        else $error("clearing measure while asleep failed");

    c_measure: cover property (@(posedge clock) disable iff (!reset_n)
        state_r == MODE_STANDBY ##1 state_r == MODE_MEASURE);
    c_sleep: cover property (@(posedge clock) disable iff (!reset_n)
        state_r == MODE_MEASURE ##1 state_r == MODE_SLEEP);
    c_lp_conv: cover property (@(posedge clock) disable iff (!reset_n)
        sample_tick_r && !conv_tick_r);

endmodule // smpc_power_ctrl

// [tb/smpc_host_model.sv]
// Host processor model that drives the register port
module smpc_host_model
    import smpc_pkg::*;
(
    input wire logic clock,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One write strobe; stale address and data are inverted afterwards
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // One read strobe; data is taken one cycle after the strobe edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule // smpc_host_model

// [tb/tb_sensor_power_mode_control.sv]
// Self-checking testbench for the sensor power-mode controller
module tb_sensor_power_mode_control
    import smpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TICKS = 4;
    localparam int SECS = 16;

    logic clock, reset_n, iface_ok, main_ok, sample_valid, reg_wr, reg_rd;
    logic [7:0] sample_level, reg_addr, reg_wdata, reg_rdata;
    logic [1:0] mode;
    logic sample_tick, conv_tick, low_power_active;
    int error_cnt = 0;
    int n_compared = 0;

    // -------------------------------------------------------------
    // Design, host model and clock
    // -------------------------------------------------------------
    smpc_power_ctrl #(.TICK_CYCLES(TICKS), .SEC_CYCLES(SECS)) dut_u (
        .clock(clock), .reset_n(reset_n), .ce(1'b1),
        .main_supply_ok(main_ok), .interface_supply_ok(iface_ok),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .sample_valid(sample_valid),
        .sample_level(sample_level), .reg_rdata(reg_rdata),
        .mode(mode), .sample_tick(sample_tick),
        .conv_tick(conv_tick), .low_power_active(low_power_active)
    );

    smpc_host_model host_u (
        .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    // Free-running 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // -------------------------------------------------------------
    // Shared helpers
    // -------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
        logic [7:0] d;
        host_u.read_reg(a, d);
        check(what, 16'(d), 16'(exp));
    endtask

    // Power write, then let the mode settle
    task automatic set_power(input logic [7:0] d);
        host_u.write_reg(ADDR_POWER, d);
        cyc(2);
    endtask

    // Count output and conversion ticks until nt outputs or lim cycles
    task automatic count_ticks(input int nt, input int lim,
                               output int ns, output int nc);
        ns = 0;
        nc = 0;
        for (int i = 0; i < lim && ns < nt; i++) begin
            @(negedge clock);
            ns += int'(sample_tick);
            nc += int'(conv_tick);
        end
    endtask

    // Cycles between two output ticks
    task automatic period(output int p);
        int i;
        i = 0;
        do begin
            @(negedge clock);
            i++;
        end while (sample_tick !== 1'b1 && i < 5000);
        p = 0;
        do begin
            @(negedge clock);
            p++;
        end while (sample_tick !== 1'b1 && p < 5000);
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_reset();
        int ns, nc;
        check("mode", 16'(mode), 16'(MODE_STANDBY));
        rd_chk("thresh", ADDR_INACT_THRESH, RST_INACT_THRESH);
        rd_chk("time", ADDR_INACT_TIME, RST_INACT_TIME);
        rd_chk("rate", ADDR_RATE, RST_RATE);
        rd_chk("power", ADDR_POWER, RST_POWER);
        rd_chk("unmapped", 8'h30, RD_UNMAPPED);
        count_ticks(1, 300, ns, nc);
        check("standby ticks", 16'(ns), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_supply();
        iface_ok = 1'b0;
        cyc(4);
        host_u.write_reg(ADDR_RATE, 8'h0B);
        set_power(8'h08);
        check("mode no iface", 16'(mode), 16'(MODE_STANDBY));
        iface_ok = 1'b1;
        cyc(4);
        rd_chk("rate dropped", ADDR_RATE, RST_RATE);
        // Losing the main supply forces standby until it returns
        set_power(8'h08);
        main_ok = 1'b0;
        cyc(4);
        check("mode no main", 16'(mode), 16'(MODE_STANDBY));
        main_ok = 1'b1;
        cyc(4);
        check("mode main back", 16'(mode), 16'(MODE_MEASURE));
        set_power(8'h00);
        $display("test supply done");
    endtask

    task automatic t_standby_rw();
        host_u.write_reg(ADDR_INACT_THRESH, 8'h5A);
        host_u.write_reg(ADDR_INACT_TIME, 8'hA5);
        host_u.write_reg(ADDR_RATE, 8'h1C);
        host_u.write_reg(ADDR_POWER, 8'h20);
        host_u.write_reg(ADDR_MODE_STATUS, 8'h01);
        rd_chk("thresh", ADDR_INACT_THRESH, 8'h5A);
        rd_chk("time", ADDR_INACT_TIME, 8'hA5);
        rd_chk("rate", ADDR_RATE, 8'h1C);
        rd_chk("power", ADDR_POWER, 8'h20);
        rd_chk("status", ADDR_MODE_STATUS, 8'h00);
        host_u.write_reg(ADDR_POWER, 8'h00);
        $display("test standby access done");
    endtask

    task automatic t_rates();
        int p, ns, nc;
        for (int c = 6; c <= 15; c++) begin
            host_u.write_reg(ADDR_RATE, 8'(c));
            set_power(8'h08);
            check("mode on", 16'(mode), 16'(MODE_MEASURE));
            period(p);
            check("period", 16'(p), 16'(TICKS << (15 - c)));
            set_power(8'h00);
            check("mode off", 16'(mode), 16'(MODE_STANDBY));
            count_ticks(1, 300, ns, nc);
            check("ticks off", 16'(ns), 16'h0000);
        end
        $display("test rate codes done");
    endtask

    task automatic t_low_power();
        int ns, nc;
        host_u.write_reg(ADDR_RATE, 8'h1A);
        cyc(2);
        check("lp on", 16'(low_power_active), 16'h0001);
        set_power(8'h08);
        count_ticks(8, 4000, ns, nc);
        check("lp conv", 16'(nc), 16'h0004);
        set_power(8'h00);
        host_u.write_reg(ADDR_RATE, 8'h1D);
        set_power(8'h08);
        count_ticks(8, 1000, ns, nc);
        check("lp high conv", 16'(nc), 16'h0008);
        set_power(8'h00);
        host_u.write_reg(ADDR_RATE, 8'h0A);
        cyc(2);
        check("lp off", 16'(low_power_active), 16'h0000);
        $display("test low power done");
    endtask

    task automatic t_autosleep();
        int i;
        host_u.write_reg(ADDR_INACT_THRESH, 8'h40);
        host_u.write_reg(ADDR_INACT_TIME, 8'h02);
        set_power(8'h38);
        check("as measure", 16'(mode), 16'(MODE_MEASURE));
        // Quiet samples at the threshold, one burst above it
        for (i = 0; i < 45; i++) begin
            @(negedge clock);
            sample_valid = (i % 4 == 0);
            sample_level = (i == 20) ? 8'h41 : 8'h40;
        end
        check("restart", 16'(mode), 16'(MODE_MEASURE));
        i = 0;
        while (mode !== MODE_SLEEP && i < 20) begin
            @(negedge clock);
            i++;
        end
        sample_valid = 1'b0;
        check("sleep", 16'(mode), 16'(MODE_SLEEP));
        set_power(8'h30);
        check("sleep off", 16'(mode), 16'(MODE_STANDBY));
        rd_chk("kept", ADDR_INACT_THRESH, 8'h40);
        set_power(8'h38);
        cyc(20);
        check("fresh timer", 16'(mode), 16'(MODE_MEASURE));
        cyc(16);
        check("sleep again", 16'(mode), 16'(MODE_SLEEP));
        // Dropping the autosleep bit wakes the part and stops the timer
        set_power(8'h28);
        check("auto off", 16'(mode), 16'(MODE_MEASURE));
        cyc(40);
        check("auto off stays", 16'(mode), 16'(MODE_MEASURE));
        set_power(8'h00);
        $display("test autosleep done");
    endtask

    // -------------------------------------------------------------
    // Main sequence and watchdog
    // -------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        iface_ok = 1'b1;
        main_ok = 1'b1;
        sample_valid = 1'b0;
        sample_level = 8'h00;
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        cyc(5);
        t_reset();
        t_supply();
        t_standby_rw();
        t_rates();
        t_low_power();
        t_autosleep();
        close_out();
    end

    // Cut a hang short well past the expected run length
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        $display("unexpected watchdog: expected done seen hang");
        close_out();
    end
endmodule // tb_sensor_power_mode_control
